// file: hw/mqws_pkg.sv
// Constants and carrier types for the multi-queue write port select.
// Assumes one 10 MHz clock and a synchronous active-low reset.
// Operation
// - Store word only while write strobe low
// - Queue selection ignores write strobe level
// - New queue written from second edge on
// - Selection edge and next use old queue
// - Flag bus selection needs no write strobe
// - Select bus is six bits wide
// - Low three select bits pick queue
// - High three bits must match device id
// - Queue selection captured while address latch high
// - Flag strobe picks device driving flag bus
// - Flag selection ignores low select bits
// - Flag selection edge keeps previous write queue
package mqws_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Widths and sizes
  localparam int DATA_W = 18; // Input word width
  localparam int QUEUES = 8; // Queues per device
  localparam int Q_W = 3; // Queue index width
  localparam int DEV_W = 3; // Device index width
  localparam int SEL_W = 6; // Select bus width
  localparam int SEL_Q_LSB = 0; // Queue field position
  localparam int SEL_DEV_LSB = 3; // Device field position
  localparam int PTR_W = 4; // Per-queue pointer width
  localparam int CNT_W = 5; // Per-queue fill count width
  localparam int ADDR_W = Q_W + PTR_W; // Memory address width
  localparam int MEM_WORDS = 128; // Storage words, all queues

  ////////////////////////////////////////////////////////////////////////
  // Levels and reset values
  localparam logic [CNT_W-1:0] Q_DEPTH = 5'h10; // Words per queue
  localparam logic [CNT_W-1:0] AF_LEVEL = 5'h0c; // Almost-full level
  localparam logic [Q_W-1:0] RST_QUEUE = 3'h0; // Queue after reset
  localparam logic [DEV_W-1:0] RST_DEV = 3'h0; // Device after reset

  ////////////////////////////////////////////////////////////////////////
  // Write port pins travelling together through the synchroniser
  typedef struct packed {
    logic writeStrobeN; // Active-low write strobe
    logic writeAddrLatch; // Queue change strobe
    logic flagStrobe; // Flag bus device select strobe
    logic [SEL_W-1:0] writeSelectBus; // Queue and device index
    logic [DATA_W-1:0] dataIn; // Input word
  } mqws_pins_t;

  // Idle pin state: strobes inactive
  localparam mqws_pins_t PINS_IDLE = '{writeStrobeN: 1'b1, default: '0};

endpackage

// file: hw/mqws_mem.sv
// Storage array shared by all eight queues.
// Assumes the caller keeps write and read addresses in range.
`timescale 1ns/1ps
module mqws_mem
  import mqws_pkg::*;
(
  input wire logic clk,
  input wire logic we,
  input wire logic [ADDR_W-1:0] wAddr,
  input wire logic [DATA_W-1:0] wData,
  input wire logic re,
  input wire logic [ADDR_W-1:0] rAddr,
  output logic [DATA_W-1:0] rData_q
);

  logic [DATA_W-1:0] mem [MEM_WORDS]; // Word array, no reset
  logic [DATA_W-1:0] rData_d; // Next read word

  ////////////////////////////////////////////////////////////////////////
  // Read word held until the next read
  always_comb
  begin
    rData_d = re ? mem[rAddr] : rData_q;
  end

  // Array write and registered read data
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[wAddr] <= wData;
    end
    rData_q <= rData_d;
  end

endmodule // mqws_mem

// file: hw/mqws_write_port.sv
// Write port queue select and expansion device select of a multi-queue
// buffer, with per-queue storage, fill counts and almost-full flag bus.
// Assumes free-running clk; pins arrive asynchronously, read side is
// on-chip logic on the same clock.
`timescale 1ns/1ps
module mqws_write_port
  import mqws_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic writeStrobeN,
  input wire logic writeAddrLatch,
  input wire logic flagStrobe,
  input wire logic [SEL_W-1:0] writeSelectBus,
  input wire logic [DATA_W-1:0] dataIn,
  input wire logic [DEV_W-1:0] devIdStrap,
  input wire logic readReq,
  input wire logic [Q_W-1:0] readQueue,
  output logic [DATA_W-1:0] readData_q,
  output logic readValid_q,
  output logic fullFlagN_q,
  output logic [QUEUES-1:0] almostFullFlagBus_q,
  output logic almostFullFlagOe_q
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Queue has no room left
  function automatic logic qFull(input logic [CNT_W-1:0] c);
    qFull = (c >= Q_DEPTH);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser: two stages before any logic looks at a pin

  mqws_pins_t pinsRaw; // Pins gathered
  mqws_pins_t pins1_q, pins1_d; // First stage, read by second only
  mqws_pins_t pins2_q, pins2_d; // Second stage, usable
  logic [DEV_W-1:0] strap1_q, strap1_d; // Strap first stage
  logic [DEV_W-1:0] strap2_q, strap2_d; // Strap second stage
  logic [DEV_W-1:0] devId_q, devId_d; // Own expansion id

  assign pinsRaw = '{writeStrobeN: writeStrobeN,
                     writeAddrLatch: writeAddrLatch,
                     flagStrobe: flagStrobe,
                     writeSelectBus: writeSelectBus,
                     dataIn: dataIn};

  // Shift stages; id caught while reset is held
  always_comb
  begin
    pins1_d = pinsRaw;
    pins2_d = pins1_q;
    strap1_d = devIdStrap;
    strap2_d = strap1_q;
    devId_d = rst_n ? devId_q : strap2_q; // Strap is static after reset
  end

  // Strobes reset to idle so no false selection after reset
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pins1_q <= PINS_IDLE;
      pins2_q <= PINS_IDLE;
    end
    else
    begin
      pins1_q <= pins1_d;
      pins2_q <= pins2_d;
    end
    strap1_q <= strap1_d;
    strap2_q <= strap2_d;
    devId_q <= devId_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // Queue and device selection

  logic capture; // Queue change this cycle
  logic flagSel; // Flag bus device change this cycle
  logic [Q_W-1:0] selQueue; // Queue field of select bus
  logic [DEV_W-1:0] selDev; // Device field of select bus
  logic [Q_W-1:0] pendQueue_q, pendQueue_d; // Captured queue
  logic [DEV_W-1:0] pendDev_q, pendDev_d; // Captured device
  logic [Q_W-1:0] activeQueue_q, activeQueue_d; // Queue being written
  logic activeHit_q, activeHit_d; // Selection addresses this device
  logic [DEV_W-1:0] flagDev_q, flagDev_d; // Device owning flag bus

  assign capture = pins2_q.writeAddrLatch;
  assign flagSel = pins2_q.flagStrobe;
  assign selQueue = pins2_q.writeSelectBus[SEL_Q_LSB +: Q_W];
  assign selDev = pins2_q.writeSelectBus[SEL_DEV_LSB +: DEV_W];

  // Selection passes a pending stage before it steers writes
  always_comb
  begin
    pendQueue_d = pendQueue_q;
    pendDev_d = pendDev_q;
    flagDev_d = flagDev_q;
    if (capture)
    begin
      pendQueue_d = selQueue;
      pendDev_d = selDev;
    end
    if (flagSel)
    begin
      flagDev_d = selDev;
    end
    // One extra stage: selection edge and next edge keep old queue
    activeQueue_d = pendQueue_q;
    activeHit_d = (pendDev_q == devId_q);
  end

  // Selection registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pendQueue_q <= RST_QUEUE;
      pendDev_q <= RST_DEV;
      activeQueue_q <= RST_QUEUE;
      activeHit_q <= 1'b0;
      flagDev_q <= RST_DEV;
    end
    else
    begin
      pendQueue_q <= pendQueue_d;
      pendDev_q <= pendDev_d;
      activeQueue_q <= activeQueue_d;
      activeHit_q <= activeHit_d;
      flagDev_q <= flagDev_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-queue pointers and fill counts

  logic [PTR_W-1:0] wrPtr_q [QUEUES];
  logic [PTR_W-1:0] wrPtr_d [QUEUES];
  logic [PTR_W-1:0] rdPtr_q [QUEUES];
  logic [PTR_W-1:0] rdPtr_d [QUEUES];
  logic [CNT_W-1:0] cnt_q [QUEUES];
  logic [CNT_W-1:0] cnt_d [QUEUES];
  logic memWe; // Word stored this cycle
  logic rdOk; // Word popped this cycle
  logic [ADDR_W-1:0] memWAddr; // Store address
  logic [ADDR_W-1:0] memRAddr; // Fetch address

  // Full queue drops the word rather than overwrite older data
  assign memWe = !pins2_q.writeStrobeN && activeHit_q
                 && !qFull(cnt_q[activeQueue_q]);
  assign rdOk = readReq && (cnt_q[readQueue] != '0);
  assign memWAddr = {activeQueue_q, wrPtr_q[activeQueue_q]};
  assign memRAddr = {readQueue, rdPtr_q[readQueue]};

  // Advance pointers and counts of the touched queues
  always_comb
  begin
    logic inc;
    logic dec;
    inc = 1'b0;
    dec = 1'b0;
    for (int i = 0; i < QUEUES; i++)
    begin
      inc = memWe && (activeQueue_q == Q_W'(i));
      dec = rdOk && (readQueue == Q_W'(i));
      wrPtr_d[i] = wrPtr_q[i] + PTR_W'(inc);
      rdPtr_d[i] = rdPtr_q[i] + PTR_W'(dec);
      cnt_d[i] = cnt_q[i] + CNT_W'(inc) - CNT_W'(dec);
    end
  end

  // Pointer and count registers
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < QUEUES; i++)
    begin
      if (!rst_n)
      begin
        wrPtr_q[i] <= '0;
        rdPtr_q[i] <= '0;
        cnt_q[i] <= '0;
      end
      else
      begin
        wrPtr_q[i] <= wrPtr_d[i];
        rdPtr_q[i] <= rdPtr_d[i];
        cnt_q[i] <= cnt_d[i];
      end
    end
  end

  // Storage with registered read word
  mqws_mem uMem (
    .clk(clk),
    .we(memWe),
    .wAddr(memWAddr),
    .wData(pins2_q.dataIn),
    .re(rdOk),
    .rAddr(memRAddr),
    .rData_q(readData_q)
  );

  ////////////////////////////////////////////////////////////////////////
  // Status outputs

  logic readValid_d; // Read word valid next cycle
  logic fullFlagN_d; // Active queue full, low true
  logic [QUEUES-1:0] afBus_d; // Almost-full per queue, low true
  logic afOe_d; // This device owns the flag bus

  // Flags; bus driven only by the device picked with the flag strobe, or by device 0 from reset until the first flag strobe
  always_comb
  begin
    readValid_d = rdOk;
    fullFlagN_d = !qFull(cnt_q[activeQueue_q]);
    for (int i = 0; i < QUEUES; i++)
    begin
      afBus_d[i] = !(cnt_q[i] >= AF_LEVEL);
    end
    afOe_d = (flagDev_q == devId_q);
  end

  // Status registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      readValid_q <= 1'b0;
      fullFlagN_q <= 1'b1;
      almostFullFlagBus_q <= '1;
      almostFullFlagOe_q <= 1'b0;
    end
    else
    begin
      readValid_q <= readValid_d;
      fullFlagN_q <= fullFlagN_d;
      almostFullFlagBus_q <= afBus_d;
      almostFullFlagOe_q <= afOe_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  writeGate_a: assert property (
    pins2_q.writeStrobeN && !rdOk |=>
      cnt_q[$past(activeQueue_q)] == $past(cnt_q[activeQueue_q]))
    else $error("write stored while strobe high");

  writeCount_a: assert property (
    memWe && !rdOk |=>
      cnt_q[$past(activeQueue_q)] == $past(cnt_q[activeQueue_q]) + 1)
    else $error("stored word not counted");

  pendSel_a: assert property (
    capture |=> pendQueue_q == $past(selQueue))
    else $error("queue selection not captured");

  selDelay_a: assert property (
    capture |-> ##2 activeQueue_q == $past(selQueue, 2))
    else $error("new queue not active on second edge");

  oldQueue_a: assert property (
    capture && !$past(capture) |=> $stable(activeQueue_q))
    else $error("queue switched too early");

  queueAddr_a: assert property (
    capture |-> ##2 (!memWe || memWAddr[ADDR_W-1 -: Q_W] ==
      $past(selQueue, 2)))
    else $error("write into wrong queue");

  devMatch_a: assert property (
    capture |-> ##2 activeHit_q == ($past(selDev, 2) == devId_q))
    else $error("device match wrong");

  flagSel_a: assert property (
    flagSel |=> flagDev_q == $past(selDev))
    else $error("flag device not captured");

  flagOe_a: assert property (
    flagSel |-> ##2 almostFullFlagOe_q == ($past(selDev, 2) == devId_q))
    else $error("flag bus owner wrong");

  flagKeep_a: assert property (
    flagSel && !capture |=> $stable(pendQueue_q) && $stable(pendDev_q))
    else $error("flag strobe moved write queue");

  noHit_a: assert property (
    memWe |-> $past(pendDev_q) == devId_q)
    else $error("unmatched device stored word");

  selWrite_c: cover property (capture ##2 memWe);
  flagOwn_c: cover property (flagSel ##2 almostFullFlagOe_q);
  queueFull_c: cover property (!fullFlagN_q);
  devMiss_c: cover property (!activeHit_q && !pins2_q.writeStrobeN);

endmodule // mqws_write_port

// file: verification/mqws_writer_model.sv
// Writer-side model that drives the write port pins.
// Assumes pins launch just after a rising clk edge.
`timescale 1ns/1ps
module mqws_writer_model
  import mqws_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  output mqws_pins_t pins
);
  logic [SEL_W-1:0] lastSel; // Last select value shown

  initial pins = PINS_IDLE;
  initial lastSel = '0;

  //////////////////////////////////////////////////
  // One pin cycle. An unqualified select bus shows the inverse of its
  // last value, so a design that looks at it anyway goes wrong.
  task automatic cyc(input logic wrN, input logic latch,
    input logic flag_strobe, input logic [SEL_W-1:0] sel,
    input logic [DATA_W-1:0] d);
    mqws_pins_t p;
    wait (rst_n === 1'b1);
    p.writeStrobeN = wrN;
    p.writeAddrLatch = latch;
    p.flagStrobe = flag_strobe & ~latch;
    p.writeSelectBus = (latch | flag_strobe) ? sel : ~lastSel;
    p.dataIn = wrN ? ~pins.dataIn : d;
    lastSel = p.writeSelectBus;
    @(posedge clk);
    pins <= p;
  endtask

  // Idle cycles: no strobe, bus lines keep moving
  task automatic idle(input int n);
    repeat (n) cyc(1'b1, 1'b0, 1'b0, '0, '0);
  endtask
endmodule // mqws_writer_model

// file: verification/testbench.sv
// Self-checking bench for the write port queue and device select.
// Assumes writer model drives pins; read side popped by the bench.
`timescale 1ns/1ps
module testbench
  import mqws_pkg::*;
;
  logic clk; // 10 MHz clock
  logic rst_n; // Sync reset, low true
  logic readReq; // Pop request
  logic [Q_W-1:0] readQueue; // Queue to pop
  logic [DATA_W-1:0] readData_q;
  logic readValid_q;
  logic fullFlagN_q;
  logic [QUEUES-1:0] almostFullFlagBus_q;
  logic almostFullFlagOe_q;
  mqws_pins_t pins; // Writer pins
  logic [DEV_W-1:0] devIdStrap; // Own id strap, moved only under reset
  int n_mismatch;
  int comparisons;

  mqws_writer_model writer (
    .clk(clk),
    .rst_n(rst_n),
    .pins(pins)
  );

  // Id strap driven by the bench; changed only while reset is held
  mqws_write_port dut (
    .clk(clk),
    .rst_n(rst_n),
    .writeStrobeN(pins.writeStrobeN),
    .writeAddrLatch(pins.writeAddrLatch),
    .flagStrobe(pins.flagStrobe),
    .writeSelectBus(pins.writeSelectBus),
    .dataIn(pins.dataIn),
    .devIdStrap(devIdStrap),
    .readReq(readReq),
    .readQueue(readQueue),
    .readData_q(readData_q),
    .readValid_q(readValid_q),
    .fullFlagN_q(fullFlagN_q),
    .almostFullFlagBus_q(almostFullFlagBus_q),
    .almostFullFlagOe_q(almostFullFlagOe_q)
  );

  //////////////////////////////////////////////////
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Single exit point
  task automatic stop_test();
    $display("checks %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Pop one word; bounded wait for the valid pulse
  task automatic pop(input logic [Q_W-1:0] q, input logic [DATA_W-1:0] exp,
    input logic hit);
    logic got;
    got = 1'b0;
    @(posedge clk);
    readReq <= 1'b1;
    readQueue <= q;
    @(posedge clk);
    readReq <= 1'b0;
    for (int i = 0; i < 3 && !got; i++)
    begin
      #1;
      if (readValid_q === 1'b1)
        got = 1'b1;
      else
        @(posedge clk);
    end
    check(got, hit);
    if (got && hit)
      check(readData_q, exp);
    @(posedge clk);
  endtask

  // Outputs while reset is still low
  task automatic t_reset();
    check(readValid_q, 1'b0);
    check(fullFlagN_q, 1'b1);
    check(almostFullFlagBus_q, 8'hff);
    check(almostFullFlagOe_q, 1'b0);
  endtask

  // Walk all queues; writes on the change edge and next go to old queue
  task automatic t_qsel();
    for (int q = 1; q < QUEUES; q++)
    begin
      writer.cyc(1'b0, 1'b1, 1'b0, 6'(q), 18'(q * 16));
      writer.cyc(1'b0, 1'b0, 1'b0, '0, 18'(q * 16 + 1));
      writer.cyc(1'b0, 1'b0, 1'b0, '0, 18'(q * 16 + 2));
      writer.cyc(1'b1, 1'b0, 1'b0, '0, '0);
    end
    writer.idle(6);
    for (int j = 0; j < QUEUES; j++)
    begin
      if (j > 0)
        pop(3'(j), 18'(j * 16 + 2), 1'b1);
      if (j < QUEUES - 1)
      begin
        pop(3'(j), 18'(j * 16 + 16), 1'b1);
        pop(3'(j), 18'(j * 16 + 17), 1'b1);
      end
      pop(3'(j), '0, 1'b0);
    end
  endtask

  // Another device selected: writes ignored until ours is back
  task automatic t_dev();
    writer.cyc(1'b1, 1'b1, 1'b0, 6'h0a, '0);
    writer.idle(1);
    writer.cyc(1'b0, 1'b0, 1'b0, '0, 18'h00aaa);
    writer.cyc(1'b0, 1'b0, 1'b0, '0, 18'h00bbb);
    writer.cyc(1'b0, 1'b1, 1'b0, 6'h02, 18'h00ccc);
    writer.cyc(1'b0, 1'b0, 1'b0, '0, 18'h00ddd);
    writer.cyc(1'b0, 1'b0, 1'b0, '0, 18'h00eee);
    writer.idle(6);
    pop(3'h2, 18'h00eee, 1'b1);
    pop(3'h2, '0, 1'b0);
    pop(3'h7, '0, 1'b0);
  endtask

  // Flag bus device select mixed with writes, then fill to full
  task automatic t_flag();
    writer.cyc(1'b1, 1'b1, 1'b0, 6'h05, '0);
    writer.idle(1);
    for (int k = 0; k < 12; k++)
      writer.cyc(1'b0, 1'b0, k == 11, 6'h07, 18'(512 + k));
    writer.idle(6);
    check(almostFullFlagOe_q, 1'b1);
    check(almostFullFlagBus_q, 8'hdf);
    writer.cyc(1'b1, 1'b0, 1'b1, 6'h1d, '0);
    writer.idle(6);
    check(almostFullFlagOe_q, 1'b0);
    writer.cyc(1'b1, 1'b0, 1'b1, 6'h00, '0);
    writer.idle(6);
    check(almostFullFlagOe_q, 1'b1);
    for (int k = 12; k < 17; k++)
      writer.cyc(1'b0, 1'b0, 1'b0, '0, 18'(512 + k));
    writer.idle(6);
    check(fullFlagN_q, 1'b0);
    for (int k = 0; k < 16; k++)
      pop(3'h5, 18'(512 + k), 1'b1);
    pop(3'h5, '0, 1'b0);
    check(almostFullFlagBus_q, 8'hff);
  endtask

  // Mid-run reset with strap 3: reset selection of device 0 is not ours
  task automatic t_strap();
    rst_n <= 1'b0;
    devIdStrap <= 3'h3;
    repeat (4) @(posedge clk);
    t_reset();
    rst_n <= 1'b1;
    writer.idle(1);
    writer.cyc(1'b0, 1'b0, 1'b0, '0, 18'h00111);
    writer.cyc(1'b0, 1'b1, 1'b0, 6'h1c, 18'h00222);
    writer.cyc(1'b0, 1'b0, 1'b0, '0, 18'h00333);
    check(almostFullFlagOe_q, 1'b0);
    writer.cyc(1'b0, 1'b0, 1'b0, '0, 18'h00444);
    writer.cyc(1'b1, 1'b0, 1'b1, 6'h18, '0);
    writer.idle(6);
    check(almostFullFlagOe_q, 1'b1);
    pop(3'h4, 18'h00444, 1'b1);
    pop(3'h4, '0, 1'b0);
    pop(3'h0, '0, 1'b0);
  endtask

  //////////////////////////////////////////////////
  // Clock, 100 ns period
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Main sequence
  initial
  begin
    n_mismatch = 0;
    comparisons = 0;
    rst_n = 1'b0;
    devIdStrap = 3'h0;
    readReq = 1'b0;
    readQueue = '0;
    repeat (12) @(posedge clk);
    t_reset();
    rst_n <= 1'b1;
    writer.idle(4);
    t_qsel();
    t_dev();
    t_flag();
    t_strap();
    stop_test();
  end

  // Watchdog, far beyond the few hundred cycles needed
  initial
  begin
    #500000;
    n_mismatch++;
    stop_test();
  end
endmodule // testbench
